// *** paw_defs.svh ***
`ifndef PAW_DEFS_SVH
`define PAW_DEFS_SVH

// Register indexes; the byte address on the bus is four times the index.
`define PAW_IDX_DUR      8'hE0
`define PAW_IDX_DMA      8'hE4
`define PAW_IDX_AREA     8'hE5
`define PAW_IDX_BASE     8'hE6
`define PAW_IDX_RANGE    8'hE7
`define PAW_IDX_TRAP_A   8'hE8
`define PAW_IDX_TRAP_B   8'hE9
`define PAW_IDX_LP_VAL   8'hEA
`define PAW_IDX_RET_VAL  8'hEB
`define PAW_IDX_WAKE     8'hEE
`define PAW_IDX_PPCTL    8'hF9

// Reset values.
`define PAW_RST_DMA      8'h00
`define PAW_RST_AREA     8'h00
`define PAW_RST_BASE     8'h00
`define PAW_RST_RANGE    8'h00
`define PAW_RST_TRAP     8'h08
`define PAW_RST_LP_VAL   3'h0
`define PAW_RST_RET_VAL  3'h7
`define PAW_RST_PPCTL    8'h40
`define PAW_RST_DUR      3'h0

// Field positions.
`define PAW_DMA_UNUSED   4
`define PAW_AREA_RANGE   7
`define PAW_AREA_VIDMEM  6
`define PAW_AREA_DISP    5
`define PAW_AREA_HDISK   4
`define PAW_AREA_FLOPPY  3
`define PAW_AREA_KBD     2
`define PAW_AREA_LOCAL_DEVICE_CLAIM    1
`define PAW_AREA_LOCAL_MASTER_REQUEST    0
`define PAW_RNG_STRICT   7
`define PAW_RNG_FLAG     3
`define PAW_WAKE_MASTER  7
`define PAW_WAKE_DMA     6
`define PAW_PP_LOAD      6

// Idle countdown durations in seconds.
`define PAW_DUR_0        14'h000F
`define PAW_DUR_1        14'h0078
`define PAW_DUR_2        14'h012C
`define PAW_DUR_3        14'h0384
`define PAW_DUR_4        14'h0708
`define PAW_DUR_5        14'h0A8C
`define PAW_DUR_6        14'h0E10
`define PAW_DUR_7        14'h3840

`endif

// *** paw_pkg.sv ***
package paw_pkg;

  typedef logic [10:0] paw_sync_t;

  typedef struct packed {
    logic         wait_r;
    logic [7:0]   rdata_r;
    logic [2:0]   dur_sel_r;
    logic [13:0]  dur_sec_r;
    logic [7:0]   dma_en_r;
    logic [7:0]   area_en_r;
    logic [7:0]   base_lo_r;
    logic [7:0]   rng_ctl_r;
    logic         smi_flag_r;
    logic [7:0]   trap_a_r;
    logic [7:0]   trap_b_r;
    logic [2:0]   lp_val_r;
    logic [2:0]   ret_val_r;
    logic         master_wake_en_r;
    logic         dma_wake_en_r;
    logic [1:0]   wake_misc_r;
    logic         wake_flag_r;
    logic [7:0]   ppctl_r;
    paw_sync_t    s1_r;
    paw_sync_t    s2_r;
    paw_sync_t    s3_r;
    paw_sync_t    filt_r;
    logic         reload_r;
    logic         strobe_r;
    logic [2:0]   port_r;
    logic         smi_seen_r;
    logic         remap_r;
    logic         trap_a_hit_r;
    logic         trap_b_hit_r;
  } paw_state_s;

endpackage

// *** paw_src_model.sv ***
`timescale 1ns/1ps
// Activity source model: turns bench commands into the asynchronous
// request lines, changing them only just after a rising clock edge.
module paw_src_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] dma_cmd_i,
  input  wire logic       claim_cmd_i,
  input  wire logic       mreq_cmd_i,
  input  wire logic       act_cmd_i,
  output logic      [7:0] dma_req_o,
  output logic            claim_b_o,
  output logic            mreq_b_o,
  output logic            act_b_o
);
  initial begin
    dma_req_o = 8'h00;
    claim_b_o = 1'b1;
    mreq_b_o  = 1'b1;
    act_b_o   = 1'b1;
  end
  always @(posedge mclk_i) begin
    dma_req_o <= dma_cmd_i;
    claim_b_o <= !claim_cmd_i;
    mreq_b_o  <= !mreq_cmd_i;
    act_b_o   <= !act_cmd_i;
  end
endmodule

// *** paw_wake_detect.sv ***
`timescale 1ns/1ps
// What this block does
// - Low power DMA reloads; strobes only with enable.
// - Normal state enabled DMA line other than line 4 reloads countdown.
// - Range access wakes in low power, reloads otherwise.
// - Bits 3-2 watch floppy data, keyboard ports.
// - Fixed areas wake in low power, else reload.
// - Device claim wakes in low power, else reload.
// - Master request wakes only with both enables.
// - Range base is ten bits from two registers.
// - Mask code ignores zero to six low bits.
// - Management interrupt flag, cleared by range write, or by a range read that returns bit 3 set.
// - Remap needs active signal, optionally after interrupt.
// - Trap A compares vector number to A9..A2.
// - Trap B likewise; both reset to vector 8.
// - Low power values copied to port on entry.
// - Port latch loads only with load enable.
// - Every wake event reloads and strobes.
// - Duration select maps codes to fixed durations.
// - Wake control bit 6 enables DMA wake.
// - Wake control bit 7 enables master wake.
`include "paw_defs.svh"

module paw_wake_detect (
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [7:0]  dma_req_i,
  input  wire logic        local_device_claim_b_i,
  input  wire logic        local_master_request_b_i,
  input  wire logic        mgmt_mode_active_b_i,
  input  wire logic        mgmt_int_i,
  input  wire logic        low_power_state_i,
  input  wire logic        enter_strobe_i,
  input  wire logic        access_io_i,
  input  wire logic        access_mem_i,
  input  wire logic [19:0] access_addr_i,
  output logic             countdown_reload_o,
  output logic             power_port_strobe_o,
  output logic             lowpower_hsync_ctl_o,
  output logic             lowpower_vsync_ctl_o,
  output logic             lowpower_clock_ctl_o,
  output logic             mgmt_remap_o,
  output logic             trap_a_hit_o,
  output logic             trap_b_hit_o,
  output logic      [13:0] idle_duration_sec_o
);

  paw_pkg::paw_state_s s;
  paw_pkg::paw_state_s n;

  logic [10:0] act_now;
  logic [10:0] act_old;
  logic [10:0] rise;
  logic [7:0]  idx;
  logic        acc;
  logic        dma_hit;
  logic        range_hit;
  logic [4:0]  area_hit;
  logic        local_device_claim_hit;
  logic        local_master_request_hit;
  logic        any_normal;
  logic        any_wake;
  logic        wake;
  logic        rng_clr;
  logic        wake_clr;
  logic [9:0]  range_base;
  logic [9:0]  io_a;

  function automatic logic [9:0] paw_cmp_mask(input logic [2:0] code);
    case (code)
      3'h0:    paw_cmp_mask = 10'h3FF;
      3'h1:    paw_cmp_mask = 10'h3FE;
      3'h2:    paw_cmp_mask = 10'h3FC;
      3'h3:    paw_cmp_mask = 10'h3F8;
      3'h4:    paw_cmp_mask = 10'h3F0;
      3'h5:    paw_cmp_mask = 10'h3E0;
      default: paw_cmp_mask = 10'h3C0;
    endcase
  endfunction

  function automatic logic paw_span(input logic [9:0] a,
                                    input logic [9:0] lo,
                                    input logic [9:0] hi);
    paw_span = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [13:0] paw_dur(input logic [2:0] code);
    case (code)
      3'h0:    paw_dur = `PAW_DUR_0;
      3'h1:    paw_dur = `PAW_DUR_1;
      3'h2:    paw_dur = `PAW_DUR_2;
      3'h3:    paw_dur = `PAW_DUR_3;
      3'h4:    paw_dur = `PAW_DUR_4;
      3'h5:    paw_dur = `PAW_DUR_5;
      3'h6:    paw_dur = `PAW_DUR_6;
      default: paw_dur = `PAW_DUR_7;
    endcase
  endfunction

  always_comb begin
    n = s;
    n.reload_r = 1'b0;
    n.strobe_r = 1'b0;
    n.trap_a_hit_r = 1'b0;
    n.trap_b_hit_r = 1'b0;
    idx = avs_address_i[9:2];
    io_a = access_addr_i[9:0];

    // Three-stage capture; a level counts once stages two and three agree.
    n.s1_r = {mgmt_mode_active_b_i, local_master_request_b_i,
              local_device_claim_b_i, dma_req_i};
    n.s2_r = s.s1_r;
    n.s3_r = s.s2_r;
    n.filt_r = (s.s2_r & ~(s.s2_r ^ s.s3_r)) | (s.filt_r & (s.s2_r ^ s.s3_r));
    act_now = {~n.filt_r[10:8], n.filt_r[7:0]};
    act_old = {~s.filt_r[10:8], s.filt_r[7:0]};
    rise = act_now & ~act_old;

    dma_hit = |(rise[7:0] & s.dma_en_r & ~(8'h01 << `PAW_DMA_UNUSED));
    range_base = {s.rng_ctl_r[1:0], s.base_lo_r};
    range_hit = access_io_i && s.area_en_r[`PAW_AREA_RANGE] &&
                (((io_a ^ range_base) & paw_cmp_mask(s.rng_ctl_r[6:4]))
                 == 10'h000);
    area_hit[4] = access_mem_i && (access_addr_i[19:17] == 3'h5);
    area_hit[3] = access_io_i && paw_span(io_a, 10'h3B0, 10'h3DF);
    area_hit[2] = access_io_i && (paw_span(io_a, 10'h1F0, 10'h1F7) ||
                                  (io_a == 10'h3F6));
    area_hit[1] = access_io_i && (io_a == 10'h3F5);
    area_hit[0] = access_io_i && ((io_a == 10'h060) || (io_a == 10'h064));
    area_hit = area_hit & s.area_en_r[6:2];
    local_device_claim_hit = rise[8] && s.area_en_r[`PAW_AREA_LOCAL_DEVICE_CLAIM];
    local_master_request_hit = rise[9] && s.area_en_r[`PAW_AREA_LOCAL_MASTER_REQUEST];

    any_normal = dma_hit || range_hit || (|area_hit) || local_device_claim_hit || local_master_request_hit;
    any_wake = (dma_hit && s.dma_wake_en_r) || range_hit || (|area_hit) ||
               local_device_claim_hit || (local_master_request_hit && s.master_wake_en_r);
    wake = low_power_state_i && any_wake;

    if (low_power_state_i) begin
      n.reload_r = dma_hit || any_wake;
    end else begin
      n.reload_r = any_normal;
    end
    n.strobe_r = wake || enter_strobe_i;

    if (s.ppctl_r[`PAW_PP_LOAD]) begin
      if (enter_strobe_i) begin
        n.port_r = s.lp_val_r;
      end else if (wake) begin
        n.port_r = s.ret_val_r;
      end
    end

    if (access_mem_i && (access_addr_i[19:10] == 10'h000)) begin
      n.trap_a_hit_r = (access_addr_i[9:2] == s.trap_a_r);
      n.trap_b_hit_r = (access_addr_i[9:2] == s.trap_b_r);
    end

    if (mgmt_int_i) begin
      n.smi_seen_r = 1'b1;
    end else if (rise[10] == 1'b0 && act_now[10] == 1'b0 && act_old[10]) begin
      n.smi_seen_r = 1'b0;
    end
    n.remap_r = act_now[10] &&
                (!s.rng_ctl_r[`PAW_RNG_STRICT] || s.smi_seen_r);

    n.dur_sec_r = paw_dur(s.dur_sel_r);

    // Avalon slave: one wait cycle, then a single accepted edge.
    acc = (avs_read_i || avs_write_i) && !s.wait_r;
    if ((avs_read_i || avs_write_i) && s.wait_r) begin
      n.wait_r = 1'b0;
      case (idx)
        `PAW_IDX_DUR:     n.rdata_r = {5'h00, s.dur_sel_r};
        `PAW_IDX_DMA:     n.rdata_r = s.dma_en_r;
        `PAW_IDX_AREA:    n.rdata_r = s.area_en_r;
        `PAW_IDX_BASE:    n.rdata_r = s.base_lo_r;
        `PAW_IDX_RANGE:   n.rdata_r = {s.rng_ctl_r[7:4], s.smi_flag_r,
                                       1'b0, s.rng_ctl_r[1:0]};
        `PAW_IDX_TRAP_A:  n.rdata_r = s.trap_a_r;
        `PAW_IDX_TRAP_B:  n.rdata_r = s.trap_b_r;
        `PAW_IDX_LP_VAL:  n.rdata_r = {5'h00, s.lp_val_r};
        `PAW_IDX_RET_VAL: n.rdata_r = {5'h00, s.ret_val_r};
        `PAW_IDX_WAKE:    n.rdata_r = {s.wake_flag_r, low_power_state_i,
                                       1'b0, s.wake_misc_r[1], 3'h0,
                                       s.wake_misc_r[0]};
        `PAW_IDX_PPCTL:   n.rdata_r = s.ppctl_r;
        default:          n.rdata_r = 8'h00;
      endcase
    end else if (acc) begin
      n.wait_r = 1'b1;
    end

    if (acc && avs_write_i && avs_byteenable_i[0]) begin
      case (idx)
        `PAW_IDX_DUR:     n.dur_sel_r = avs_writedata_i[2:0];
        `PAW_IDX_DMA:     n.dma_en_r = avs_writedata_i[7:0];
        `PAW_IDX_AREA:    n.area_en_r = avs_writedata_i[7:0];
        `PAW_IDX_BASE:    n.base_lo_r = avs_writedata_i[7:0];
        `PAW_IDX_RANGE:   n.rng_ctl_r = avs_writedata_i[7:0] & 8'hF3;
        `PAW_IDX_TRAP_A:  n.trap_a_r = avs_writedata_i[7:0];
        `PAW_IDX_TRAP_B:  n.trap_b_r = avs_writedata_i[7:0];
        `PAW_IDX_LP_VAL:  n.lp_val_r = avs_writedata_i[2:0];
        `PAW_IDX_RET_VAL: n.ret_val_r = avs_writedata_i[2:0];
        `PAW_IDX_WAKE: begin
          n.master_wake_en_r = avs_writedata_i[`PAW_WAKE_MASTER];
          n.dma_wake_en_r = avs_writedata_i[`PAW_WAKE_DMA];
          n.wake_misc_r = {avs_writedata_i[4], avs_writedata_i[0]};
        end
        `PAW_IDX_PPCTL:   n.ppctl_r = avs_writedata_i[7:0];
        default: begin
        end
      endcase
    end

    rng_clr = acc && (idx == `PAW_IDX_RANGE) &&
              (avs_write_i || s.rdata_r[`PAW_RNG_FLAG]);
    n.smi_flag_r = (s.smi_flag_r && !rng_clr) || mgmt_int_i;
    wake_clr = acc && (idx == `PAW_IDX_WAKE) &&
               (avs_write_i || s.rdata_r[7]);
    n.wake_flag_r = (s.wake_flag_r && !wake_clr) || wake;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
      s.wait_r <= 1'b1;
      s.dur_sel_r <= `PAW_RST_DUR;
      s.dur_sec_r <= `PAW_DUR_0;
      s.dma_en_r <= `PAW_RST_DMA;
      s.area_en_r <= `PAW_RST_AREA;
      s.base_lo_r <= `PAW_RST_BASE;
      s.rng_ctl_r <= `PAW_RST_RANGE;
      s.trap_a_r <= `PAW_RST_TRAP;
      s.trap_b_r <= `PAW_RST_TRAP;
      s.lp_val_r <= `PAW_RST_LP_VAL;
      s.ret_val_r <= `PAW_RST_RET_VAL;
      s.ppctl_r <= `PAW_RST_PPCTL;
      s.s1_r <= 11'h700;
      s.s2_r <= 11'h700;
      s.s3_r <= 11'h700;
      s.filt_r <= 11'h700;
      s.port_r <= `PAW_RST_RET_VAL;
    end else begin
      s <= n;
    end
  end

  assign avs_readdata_o = {24'h00_0000, s.rdata_r};
  assign avs_waitrequest_o = s.wait_r;
  assign countdown_reload_o = s.reload_r;
  assign power_port_strobe_o = s.strobe_r;
  assign lowpower_hsync_ctl_o = s.port_r[2];
  assign lowpower_vsync_ctl_o = s.port_r[1];
  assign lowpower_clock_ctl_o = s.port_r[0];
  assign mgmt_remap_o = s.remap_r;
  assign trap_a_hit_o = s.trap_a_hit_r;
  assign trap_b_hit_o = s.trap_b_hit_r;
  assign idle_duration_sec_o = s.dur_sec_r;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence seq_bus_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence

  sequence seq_bus_done;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  sequence seq_enter;
    enter_strobe_i && s.ppctl_r[`PAW_PP_LOAD];
  endsequence

  a_bus_answer: assert property (seq_bus_req |=> seq_bus_done)
    else $error("bus answer not one wait cycle");

  a_dma_reload_norm: assert property (
    !low_power_state_i && dma_hit |=> countdown_reload_o)
    else $error("normal DMA hit did not reload");

  a_dma_strobe_gate: assert property (
    low_power_state_i && dma_hit && s.dma_wake_en_r
    |=> power_port_strobe_o && countdown_reload_o)
    else $error("enabled DMA wake did not strobe");

  a_range_wake: assert property (
    low_power_state_i && range_hit |=> power_port_strobe_o)
    else $error("range hit did not wake");

  a_area_normal: assert property (
    !low_power_state_i && !enter_strobe_i && (|area_hit)
    |=> countdown_reload_o && !power_port_strobe_o)
    else $error("area hit in normal state misbehaved");

  a_local_device_claim_wake: assert property (
    low_power_state_i && local_device_claim_hit |=> power_port_strobe_o)
    else $error("device claim did not wake");

  a_local_master_request_gate: assert property (
    low_power_state_i && !enter_strobe_i && !s.master_wake_en_r &&
    local_master_request_hit && !dma_hit && !range_hit && !(|area_hit) && !local_device_claim_hit
    |=> !power_port_strobe_o && !countdown_reload_o)
    else $error("master request woke without enable");

  a_smi_flag_set: assert property (
    mgmt_int_i |=> s.smi_flag_r)
    else $error("management interrupt flag not set");

  a_remap_plain: assert property (
    !s.rng_ctl_r[`PAW_RNG_STRICT] && act_now[10] |=> mgmt_remap_o)
    else $error("remap missing while active");

  a_trap_vector: assert property (
    access_mem_i && (access_addr_i[19:10] == 10'h000) &&
    (access_addr_i[9:2] == s.trap_a_r) |=> trap_a_hit_o)
    else $error("trap A missed its vector");

  a_port_copy: assert property (
    seq_enter ##0 ($stable(s.lp_val_r))[*2]
    |-> {lowpower_hsync_ctl_o, lowpower_vsync_ctl_o,
         lowpower_clock_ctl_o} == $past(s.lp_val_r))
    else $error("low power values not copied");

  a_port_hold: assert property (
    !s.ppctl_r[`PAW_PP_LOAD] |=> $stable(s.port_r))
    else $error("port latch loaded without enable");

  a_trap_b_vector: assert property (
    access_mem_i && (access_addr_i[19:10] == 10'h000) &&
    (access_addr_i[9:2] == s.trap_b_r) |=> trap_b_hit_o)
    else $error("trap B missed its vector");

  a_area_wake: assert property (
    low_power_state_i && (|area_hit)
    |=> power_port_strobe_o && countdown_reload_o)
    else $error("area hit in low power did not wake");

  a_master_wake: assert property (
    low_power_state_i && local_master_request_hit && s.master_wake_en_r
    |=> power_port_strobe_o && countdown_reload_o)
    else $error("enabled master request did not wake");

  a_smi_flag_clear: assert property (
    rng_clr && !mgmt_int_i |=> !s.smi_flag_r)
    else $error("management interrupt flag not cleared");

endmodule

// *** paw_wake_detect_tb_top.sv ***
`timescale 1ns/1ps
`include "paw_defs.svh"
module paw_wake_detect_tb_top;
  logic        mclk_i = 0, rst_b_i = 0;
  logic [9:0]  avs_address_i = '0;
  logic        avs_read_i = 0, avs_write_i = 0;
  logic [31:0] avs_writedata_i = '0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o, reload, strobe, hs, vs, ck, remap;
  logic        ta_hit, tb_hit;
  logic [13:0] dur_o;
  logic [7:0]  dma_cmd = 0, dma_req, rv;
  logic        claim_cmd = 0, mreq_cmd = 0, act_cmd = 0;
  logic        claim_b, mreq_b, act_b;
  logic        mgmt_int_i = 0, lp = 0, enter = 0, a_io = 0, a_mem = 0;
  logic [19:0] a_addr = '0;
  logic [19:0] lc;
  int error_cnt = 0, cmp_count = 0, rl_n = 0, st_n = 0, ta_n = 0, tb_n = 0;
  int r0, s0, i, k, n;
  logic [13:0] dur [8] = '{`PAW_DUR_0, `PAW_DUR_1, `PAW_DUR_2, `PAW_DUR_3,
                           `PAW_DUR_4, `PAW_DUR_5, `PAW_DUR_6, `PAW_DUR_7};
  logic [7:0]  ri [8] = '{8'hE4, 8'hE5, 8'hE6, 8'hE7, 8'hE8, 8'hE9, 8'hEA,
                          8'h10};
  logic [7:0]  rr [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h08, 8'h00,
                          8'h00};
  // Area table: {hit, mem, enable bit, address}.
  logic [24:0] ar [14] = '{{1'b1, 1'b0, 3'd2, 20'h0_0060},
    {1'b1, 1'b0, 3'd2, 20'h0_0064}, {1'b0, 1'b0, 3'd2, 20'h0_0062},
    {1'b1, 1'b0, 3'd3, 20'h0_03F5}, {1'b0, 1'b0, 3'd3, 20'h0_03F4},
    {1'b1, 1'b0, 3'd4, 20'h0_01F0}, {1'b1, 1'b0, 3'd4, 20'h0_01F7},
    {1'b1, 1'b0, 3'd4, 20'h0_03F6}, {1'b1, 1'b0, 3'd5, 20'h0_03B0},
    {1'b1, 1'b0, 3'd5, 20'h0_03DF}, {1'b0, 1'b0, 3'd5, 20'h0_03E0},
    {1'b1, 1'b1, 3'd6, 20'hA_0000}, {1'b1, 1'b1, 3'd6, 20'hB_FFFF},
    {1'b0, 1'b1, 3'd6, 20'hC_0000}};
  // Bus line table: {low power, E5, EE, master line, reload, strobe}.
  logic [19:0] lt [7] = '{{1'b0, 8'h02, 8'h00, 3'b010},
    {1'b1, 8'h02, 8'h00, 3'b011}, {1'b0, 8'h01, 8'h00, 3'b110},
    {1'b1, 8'h01, 8'h00, 3'b100}, {1'b1, 8'h01, 8'h80, 3'b111},
    {1'b1, 8'h00, 8'h80, 3'b100}, {1'b0, 8'h00, 8'h00, 3'b000}};

  always #4 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    if (reload === 1'b1) rl_n++;
    if (strobe === 1'b1) st_n++;
    if (ta_hit === 1'b1) ta_n++;
    if (tb_hit === 1'b1) tb_n++;
  end

  paw_src_model paw_src_model_i (
    .mclk_i(mclk_i), .dma_cmd_i(dma_cmd), .claim_cmd_i(claim_cmd),
    .mreq_cmd_i(mreq_cmd), .act_cmd_i(act_cmd), .dma_req_o(dma_req),
    .claim_b_o(claim_b), .mreq_b_o(mreq_b), .act_b_o(act_b));

  paw_wake_detect paw_wake_detect_i (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .dma_req_i(dma_req), .local_device_claim_b_i(claim_b),
    .local_master_request_b_i(mreq_b), .mgmt_mode_active_b_i(act_b),
    .mgmt_int_i(mgmt_int_i), .low_power_state_i(lp),
    .enter_strobe_i(enter), .access_io_i(a_io), .access_mem_i(a_mem),
    .access_addr_i(a_addr), .countdown_reload_o(reload),
    .power_port_strobe_o(strobe), .lowpower_hsync_ctl_o(hs),
    .lowpower_vsync_ctl_o(vs), .lowpower_clock_ctl_o(ck),
    .mgmt_remap_o(remap), .trap_a_hit_o(ta_hit), .trap_b_hit_o(tb_hit),
    .idle_duration_sec_o(dur_o));

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task tally_and_finish;
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd);
    int t;
    t = 0;
    @(posedge mclk_i);
    avs_address_i <= {idx, 2'b00};
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_writedata_i <= {24'h00_0000, wd};
    do begin
      @(posedge mclk_i);
      t++;
    end while (avs_waitrequest_o !== 1'b0 && t < 20);
    if (avs_waitrequest_o !== 1'b0) begin
      error_cnt++;
      tally_and_finish;
    end
    rd = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    xfer(1'b1, idx, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] x;
    xfer(1'b0, idx, 8'h00, x);
    check("register read", x, e);
  endtask

  task automatic hit(input logic m, input logic [19:0] a);
    @(posedge mclk_i);
    a_io <= !m;
    a_mem <= m;
    a_addr <= a;
    @(posedge mclk_i);
    a_io <= 1'b0;
    a_mem <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask

  task automatic src(input logic [7:0] d, input logic [2:0] c);
    @(posedge mclk_i);
    dma_cmd <= d;
    claim_cmd <= c[0];
    mreq_cmd <= c[1];
    act_cmd <= c[2];
    repeat (10) @(posedge mclk_i);
  endtask

  task automatic tick(input logic intr);
    @(posedge mclk_i);
    if (intr) mgmt_int_i <= 1'b1;
    else enter <= 1'b1;
    @(posedge mclk_i);
    mgmt_int_i <= 1'b0;
    enter <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask

  task snap;
    r0 = rl_n;
    s0 = st_n;
  endtask

  task automatic pulses(input int er, input int es);
    check("reload count", rl_n - r0, er);
    check("strobe count", st_n - s0, es);
  endtask

  initial begin
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    check("port", {hs, vs, ck}, 3'b111);
    check("duration", dur_o, `PAW_DUR_0);
    for (i = 0; i < 8; i++) rd_chk(ri[i], rr[i]);
    for (i = 0; i < 8; i++) begin
      wr(8'hE0, i[7:0]);
      repeat (2) @(posedge mclk_i);
      check("duration", dur_o, dur[i]);
    end
    wr(8'hE7, 8'hFB);
    rd_chk(8'hE7, 8'hF3);
    wr(8'hEA, 8'h05);
    snap;
    tick(1'b0);
    check("enter strobe", st_n - s0, 1);
    check("port", {hs, vs, ck}, 3'b101);
    wr(8'hF9, 8'h00);
    wr(8'hEA, 8'h02);
    tick(1'b0);
    check("port", {hs, vs, ck}, 3'b101);
    wr(8'hF9, 8'h40);
    for (k = 0; k < 2; k++) begin
      lp <= k[0];
      for (i = 0; i < 14; i++) begin
        wr(8'hE5, 8'h01 << ar[i][22:20]);
        snap;
        hit(ar[i][23], ar[i][19:0]);
        pulses(ar[i][24], ar[i][24] && k);
      end
    end
    check("port", {hs, vs, ck}, `PAW_RST_RET_VAL);
    wr(8'hE5, 8'h00);
    snap;
    hit(1'b0, 20'h0_0060);
    pulses(0, 0);
    lp <= 1'b0;
    wr(8'hE5, 8'h80);
    wr(8'hE6, 8'hAA);
    for (k = 0; k < 8; k++) begin
      n = (k > 5) ? 6 : k;
      wr(8'hE7, {1'b0, k[2:0], 4'b0010});
      snap;
      hit(1'b0, {10'h000, 10'h2AA ^ 10'((1 << n) - 1)});
      pulses(1, 0);
      snap;
      hit(1'b0, {10'h000, 10'h2AA ^ 10'(1 << n)});
      pulses(0, 0);
    end
    lp <= 1'b1;
    snap;
    hit(1'b0, 20'h0_02AA);
    pulses(1, 1);
    wr(8'hE5, 8'h00);
    wr(8'hE4, 8'hEF);
    for (k = 0; k < 3; k++) begin
      lp <= (k > 0);
      wr(8'hEE, (k == 2) ? 8'h40 : 8'h00);
      for (i = 0; i < 8; i++) begin
        if (i != 4) begin
          snap;
          src(8'h01 << i, 3'b000);
          src(8'h00, 3'b000);
          pulses(1, k == 2);
        end
      end
    end
    wr(8'hE4, 8'h01);
    snap;
    src(8'h02, 3'b000);
    src(8'h00, 3'b000);
    pulses(0, 0);
    wr(8'hE4, 8'h00);
    for (i = 0; i < 7; i++) begin
      lc = lt[i];
      lp <= lc[19];
      wr(8'hE5, lc[18:11]);
      wr(8'hEE, lc[10:3]);
      snap;
      src(8'h00, {1'b0, lc[2], !lc[2]});
      src(8'h00, 3'b000);
      pulses(lc[1], lc[0]);
    end
    lp <= 1'b0;
    wr(8'hE5, 8'h00);
    wr(8'hEE, 8'h00);
    wr(8'hE7, 8'h00);
    src(8'h00, 3'b100);
    check("remap", remap, 1'b1);
    src(8'h00, 3'b000);
    check("remap", remap, 1'b0);
    wr(8'hE7, 8'h80);
    src(8'h00, 3'b100);
    check("remap", remap, 1'b0);
    src(8'h00, 3'b000);
    tick(1'b1);
    src(8'h00, 3'b100);
    check("remap", remap, 1'b1);
    src(8'h00, 3'b000);
    rd_chk(8'hE7, 8'h88);
    rd_chk(8'hE7, 8'h80);
    tick(1'b1);
    wr(8'hE7, 8'h80);
    rd_chk(8'hE7, 8'h80);
    hit(1'b1, 20'h0_0020);
    hit(1'b1, 20'h0_0023);
    hit(1'b1, 20'h0_0024);
    check("trap a", ta_n, 2);
    check("trap b", tb_n, 2);
    wr(8'hE9, 8'hFF);
    hit(1'b1, 20'h0_03FC);
    check("trap a", ta_n, 2);
    check("trap b", tb_n, 3);
    tally_and_finish;
  end
endmodule
